// file: tb/lsw_node_model.sv
// end-node model: feeds frames into the core and collects egress bytes
`timescale 1ns/100ps
module lsw_node_model #(
    parameter P = 5
)(
    input wire mclk_i,
    input wire [P-1:0] rx_ready_i,
    input wire [P-1:0] tx_valid_i,
    input wire [7:0] tx_data_i,
    input wire tx_last_i,
    output reg [P-1:0] rx_valid_o = '0,
    output reg [P*8-1:0] rx_data_o = '0,
    output reg [P-1:0] rx_last_o = '0,
    output reg [P-1:0] rx_good_o = '0,
    output reg [P-1:0] tx_ready_o = '0
);
    logic [7:0] got[$];
    logic [P-1:0] mask;
    int frames = 0;
    reg [7:0] st = 8'h5a;
    // ====================
    // egress side
    // stall pattern changes every cycle
    always @(negedge mclk_i)
    begin
        st <= {st[6:0], st[7] ^ st[5] ^ st[4] ^ st[3]};
        tx_ready_o <= st[P-1:0] | {P{st[7]}};
    end
    // byte accepted when every egress port is ready
    always @(posedge mclk_i)
    begin
        if (tx_valid_i != '0 && (tx_valid_i & ~tx_ready_o) == '0)
        begin
            got.push_back(tx_data_i);
            mask = tx_valid_i;
            frames += tx_last_i;
        end
    end
    // ====================
    // ingress side
    // byte advances only after an edge that saw the grant
    task automatic send(input int p, input logic [7:0] f[$], input bit good);
        int i;
        bit t;
        i = 0;
        while (i < f.size())
        begin
            rx_valid_o[p] = 1'b1;
            rx_data_o[p*8+:8] = f[i];
            rx_last_o[p] = (i == f.size() - 1);
            rx_good_o[p] = good;
            t = rx_ready_i[p];
            @(negedge mclk_i);
            i += t;
        end
        rx_valid_o[p] = 1'b0;
        rx_last_o[p] = 1'b0;
        rx_good_o[p] = 1'b0;
        rx_data_o[p*8+:8] = ~f[f.size()-1]; // idle line no longer shows data
    endtask
endmodule // lsw_node_model

// file: tb/lsw_switch_monitor.sv
// assertion checker on the switch core ports
`timescale 1ns/100ps
module lsw_switch_monitor #(
    parameter PORTS = 5
)(
    input wire mclk_i,
    input wire rst_n_i,
    input wire [PORTS-1:0] link_det_i,
    input wire [PORTS*2-1:0] local_abil_i,
    input wire [PORTS-1:0] partner_an_i,
    input wire [PORTS*2-1:0] partner_abil_i,
    input wire [PORTS-1:0] tx_ready_i,
    input wire [PORTS-1:0] tx_valid_o,
    input wire [7:0] tx_data_o,
    input wire tx_last_o,
    input wire [PORTS-1:0] port_active_o,
    input wire [PORTS*2-1:0] port_mode_o,
    input wire [PORTS-1:0] an_start_o,
    input wire [PORTS-1:0] rx_ready_o
);
    reg [PORTS-1:0] ing;
    // ingress port of the frame in flight
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
            ing <= '0;
        else if (rx_ready_o != '0)
            ing <= rx_ready_o;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_hold;
        $stable(tx_valid_o) && $stable(tx_data_o) && $stable(tx_last_o);
    endsequence
    property p_hold;
        (tx_valid_o & ~tx_ready_i) != '0 |=> s_hold;
    endproperty
    property p_one;
        (an_start_o & $past(an_start_o)) == '0;
    endproperty
    property p_new;
        (link_det_i & ~$past(link_det_i)) != '0 |-> ##[0:3] an_start_o != '0;
    endproperty
    property p_drop;
        $fell(link_det_i[PORTS-1]) |-> ##[0:2] !port_active_o[PORTS-1];
    endproperty
    property p_ingress;
        tx_valid_o != '0 |-> (tx_valid_o & (ing | ~port_active_o)) == '0;
    endproperty
    property p_sf;
        $rose(tx_valid_o != '0) |-> rx_ready_o == '0 && $past(rx_ready_o) == '0;
    endproperty
    property p_half;
        port_active_o[PORTS-1] && !partner_an_i[PORTS-1] |-> !port_mode_o[PORTS*2-2];
    endproperty
    property p_neg;
        port_active_o[0] && partner_an_i[0] |->
            port_mode_o[1:0] == (local_abil_i[1:0] & partner_abil_i[1:0]);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled byte changed");
    a_one: assert property (p_one) else $error("start pulse too long");
    a_new: assert property (p_new) else $error("no start on cable");
    a_drop: assert property (p_drop) else $error("port stays active");
    a_ingress: assert property (p_ingress) else $error("bad egress port");
    a_sf: assert property (p_sf) else $error("sent before stored");
    a_half: assert property (p_half) else $error("sensed port full");
    a_neg: assert property (p_neg) else $error("wrong mode");
endmodule // lsw_switch_monitor
bind lsw_switch lsw_switch_monitor #(.PORTS(PORTS)) i_mon (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link_det_i(link_det_i),
    .local_abil_i(local_abil_i), .partner_an_i(partner_an_i),
    .partner_abil_i(partner_abil_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .port_active_o(port_active_o),
    .port_mode_o(port_mode_o), .an_start_o(an_start_o), .rx_ready_o(rx_ready_o));

// file: tb/lsw_switch_tb_top.sv
// self-checking bench of the switch core
`timescale 1ns/100ps
module lsw_switch_tb_top;
    localparam P = 5;
    localparam [47:0] st_a = 48'h02000000000a, st_b = 48'h02000000000b, st_c = 48'h02000000000c;
    reg mclk_i = 0;
    reg rst_n_i = 0;
    reg [P-1:0] link_det_i = '0;
    reg [P*2-1:0] local_abil_i = 10'h37f;
    reg [P-1:0] partner_an_i = 5'h0f;
    reg [P*2-1:0] partner_abil_i = 10'h0e7;
    reg [P-1:0] sensed_100_i = 5'h10;
    wire [P-1:0] rx_valid_i, rx_last_i, rx_good_i, tx_ready_i, tx_valid_o, port_active_o;
    wire [P-1:0] an_start_o, rx_ready_o;
    wire [P*8-1:0] rx_data_i;
    wire [7:0] tx_data_o;
    wire tx_last_o;
    wire [P*2-1:0] port_mode_o;
    int error_cnt = 0, n_checks = 0, tbl[logic [47:0]];
    reg [7:0] lf = 8'h3d;
    lsw_switch #(.PORTS(P), .TIMEOUT(20)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_last_i(rx_last_i),
        .rx_good_i(rx_good_i), .link_det_i(link_det_i), .local_abil_i(local_abil_i),
        .partner_an_i(partner_an_i), .partner_abil_i(partner_abil_i),
        .sensed_100_i(sensed_100_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .port_active_o(port_active_o),
        .port_mode_o(port_mode_o), .an_start_o(an_start_o), .rx_ready_o(rx_ready_o));
    lsw_node_model #(.P(P)) i_node (.mclk_i(mclk_i), .rx_ready_i(rx_ready_o),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
        .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_last_o(rx_last_i),
        .rx_good_o(rx_good_i), .tx_ready_o(tx_ready_i));
    // clock
    initial forever #25 mclk_i = ~mclk_i;
    function [7:0] lfsr8();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task chk(input logic [47:0] got, input logic [47:0] want);
        n_checks++;
        if (got !== want)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t got %0h want %0h", $time, got, want);
        end
    endtask
    task give_verdict();
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // settled link mode per port
    task modes();
        for (int p = 0; p < P; p++)
            chk(port_mode_o[p*2+:2], partner_an_i[p] ? local_abil_i[p*2+:2] &
                partner_abil_i[p*2+:2] : {sensed_100_i[p], 1'b0});
        chk(port_active_o, link_det_i);
    endtask
    // one frame through the core against the table model
    task automatic xfer(input int p, input [47:0] da, input [47:0] sa, input bit good);
        logic [7:0] f[$];
        logic [P-1:0] m;
        int fr;
        int k;
        for (int i = 0; i < 12; i++)
            f.push_back(i < 6 ? da[47-8*i-:8] : sa[95-8*i-:8]);
        repeat (2 + lf[1:0]) f.push_back(lfsr8());
        m = link_det_i & ~(5'h01 << p);
        if (!da[40] && tbl.exists(da))
            m = (tbl[da] == p) ? '0 : 5'h01 << tbl[da];
        if (!good)
            m = '0;
        else
            tbl[sa] = p;
        fr = i_node.frames;
        i_node.got = {};
        i_node.send(p, f, good);
        k = 0;
        while (m != '0 && i_node.frames == fr && k < 300)
        begin
            @(negedge mclk_i);
            k++;
        end
        repeat (m == '0 ? 30 : 1) @(negedge mclk_i);
        chk(i_node.frames, fr + (m != '0));
        if (m != '0)
        begin
            chk(i_node.mask, m);
            chk(i_node.got.size(), f.size());
            foreach (f[j])
                chk(i_node.got[j], f[j]);
        end
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(negedge mclk_i);
        rst_n_i = 1'b1;
        link_det_i = 5'h1f;
        repeat (60) @(negedge mclk_i);
        modes();
        xfer(0, st_b, st_a, 1'b1);
        xfer(1, st_a, st_b, 1'b1);
        xfer(0, st_b, st_a, 1'b1);
        xfer(3, st_a, st_c, 1'b0);
        xfer(0, st_c, st_a, 1'b1);
        xfer(2, st_b, st_a, 1'b1);
        xfer(1, st_a, st_b, 1'b1);
        xfer(2, st_a, st_c, 1'b1);
        link_det_i = 5'h0f;
        repeat (5) @(negedge mclk_i);
        xfer(2, 48'hffffffffffff, st_a, 1'b1);
        xfer(0, 48'h01005e000001, st_b, 1'b1);
        link_det_i = 5'h1f;
        repeat (60) @(negedge mclk_i);
        modes();
        give_verdict();
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        give_verdict();
    end
endmodule // lsw_switch_tb_top

// file: verilog/lsw_port_neg.v
// per-port link mode settling: autonegotiation with speed-sense fallback
`timescale 1ns/100ps
`include "lsw_regs.vh"
module lsw_port_neg #(
    parameter TIMEOUT = `LSW_AN_TIMEOUT_CYC
)(
    input wire mclk_i,
    input wire rst_n_i,
    input wire link_det_i,
    input wire [1:0] local_abil_i,
    input wire partner_an_i,
    input wire [1:0] partner_abil_i,
    input wire sensed_100_i,
    output reg active_o,
    output reg [1:0] mode_o,
    output reg an_start_o
);
    localparam [3:0] ST_DOWN = 4'h1;
    localparam [3:0] ST_NEG = 4'h2;
    localparam [3:0] ST_UP = 4'h4;
    localparam [3:0] ST_SENSE = 4'h8;
    reg [3:0] state;
    reg [31:0] timer;
    reg [1:0] common;
    // ==========================================
    // highest mode both ends support
    always @*
    begin
        common = local_abil_i;
        if (partner_abil_i[1] == 1'b0)
            common[1] = 1'b0;
        if (partner_abil_i[0] == 1'b0)
            common[0] = 1'b0;
    end
    // ==========================================
    // negotiation state machine
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_DOWN;
            timer <= 32'h0;
            active_o <= 1'b0;
            mode_o <= `LSW_MODE_10H;
            an_start_o <= 1'b0;
        end
        else
        begin
            an_start_o <= 1'b0;
            if (!link_det_i)
            begin
                state <= ST_DOWN;
                active_o <= 1'b0;
            end
            else
                case (state)
                    ST_DOWN:
                    begin
                        state <= ST_NEG; // R08
                        an_start_o <= 1'b1; // R08
                        timer <= 32'h0;
                    end
                    ST_NEG:
                    begin
                        if (partner_an_i)
                        begin
                            mode_o <= common; // R07 R11
                            active_o <= 1'b1;
                            state <= ST_UP;
                        end
                        else if (timer >= TIMEOUT - 1)
                            state <= ST_SENSE;
                        else
                            timer <= timer + 32'h1;
                    end
                    ST_SENSE:
                    begin
                        mode_o <= {sensed_100_i, 1'b0}; // R09
                        active_o <= 1'b1;
                        state <= ST_UP;
                    end
                    ST_UP:
                        active_o <= 1'b1;
                    default:
                        state <= ST_DOWN;
                endcase
        end
    end
endmodule // lsw_port_neg

// file: verilog/lsw_regs.vh
// constants of the learning switch forwarding core
`ifndef LSW_REGS_VH
`define LSW_REGS_VH
// link modes as a two bit code {speed_100, full_duplex}
`define LSW_MODE_10H 2'h0
`define LSW_MODE_10F 2'h1
`define LSW_MODE_100H 2'h2
`define LSW_MODE_100F 2'h3
// autonegotiation timeout, microseconds, and its cycle count at 20 MHz
`define LSW_AN_TIMEOUT_US 1000
`define LSW_CLK_MHZ 20
`define LSW_AN_TIMEOUT_CYC (`LSW_AN_TIMEOUT_US * `LSW_CLK_MHZ)
// frame byte positions of the address fields
`define LSW_DA_LAST 5
`define LSW_SA_LAST 11
// bit 0 of the first address byte marks group addresses
`define LSW_GROUP_BIT 0
`endif

// file: verilog/lsw_switch.v
// learning switch forwarding core with per-port link settling
// Overview of operation
// R01: a frame with a learned destination goes only to the port tied to that address.
// R02: group (multicast or broadcast) frames are copied to every active port.
// R03: the address table is built by the core itself from received traffic.
// R04: a frame with an unknown destination is flooded to all ports; the code floods it only to the active ports other than the ingress port.
// R05: a replying station's address is added with the port it replied on.
// R06: a whole frame is stored before any egress transmission starts.
// R07: each port negotiates the highest rate and duplex both ends support.
// R08: negotiation restarts whenever a new cable connection is seen.
// R09: without partner negotiation the speed is sensed and half duplex is used.
// R10: a full-duplex port receives and transmits at the same time; the core never receives while it transmits.
// R11: each port runs at 10 or 100 Mbit/s, half or full duplex.
// R12: a flooded or group frame never returns to its ingress port.
// R13: the source of each good frame is learned, replacing any older entry.
`timescale 1ns/100ps
`include "lsw_regs.vh"
module lsw_switch #(
    parameter PORTS = 5,
    parameter TBL = 16,
    parameter MAXLEN = 1536,
    parameter AW = 11,
    parameter TIMEOUT = `LSW_AN_TIMEOUT_CYC
)(
    input wire mclk_i,
    input wire rst_n_i,
    input wire [PORTS-1:0] rx_valid_i,
    input wire [PORTS*8-1:0] rx_data_i,
    input wire [PORTS-1:0] rx_last_i,
    input wire [PORTS-1:0] rx_good_i,
    input wire [PORTS-1:0] link_det_i,
    input wire [PORTS*2-1:0] local_abil_i,
    input wire [PORTS-1:0] partner_an_i,
    input wire [PORTS*2-1:0] partner_abil_i,
    input wire [PORTS-1:0] sensed_100_i,
    input wire [PORTS-1:0] tx_ready_i,
    output reg [PORTS-1:0] tx_valid_o,
    output reg [7:0] tx_data_o,
    output reg tx_last_o,
    output reg [PORTS-1:0] port_active_o,
    output reg [PORTS*2-1:0] port_mode_o,
    output reg [PORTS-1:0] an_start_o,
    output reg [PORTS-1:0] rx_ready_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RECV = 4'h2;
    localparam [3:0] ST_LOOK = 4'h4;
    localparam [3:0] ST_SEND = 4'h8;
    localparam PW = 3;
    wire [PORTS-1:0] act;
    wire [PORTS*2-1:0] mode;
    wire [PORTS-1:0] an_st;
    reg [3:0] state;
    reg [7:0] buffer [0:MAXLEN-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW-1:0] len;
    reg [PW-1:0] in_port;
    reg [47:0] dst;
    reg [47:0] src;
    reg [PORTS-1:0] egress;
    reg [47:0] tbl_addr [0:TBL-1];
    reg [PW-1:0] tbl_port [0:TBL-1];
    reg [TBL-1:0] tbl_valid;
    reg [$clog2(TBL)-1:0] tbl_next;
    reg [PW-1:0] sel;
    reg sel_ok;
    reg hit;
    reg [PW-1:0] hit_port;
    reg src_hit;
    reg [$clog2(TBL)-1:0] src_idx;
    integer i;
    integer j; // table search index, kept apart from the port scan index
    // ==========================================
    // one negotiation engine per port
    genvar g;
    generate
        for (g = 0; g < PORTS; g = g + 1)
        begin : g_port
            lsw_port_neg #(.TIMEOUT(TIMEOUT)) u_neg (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .link_det_i(link_det_i[g]),
                .local_abil_i(local_abil_i[g*2+1:g*2]),
                .partner_an_i(partner_an_i[g]),
                .partner_abil_i(partner_abil_i[g*2+1:g*2]),
                .sensed_100_i(sensed_100_i[g]),
                .active_o(act[g]),
                .mode_o(mode[g*2+1:g*2]),
                .an_start_o(an_st[g])
            );
        end
    endgenerate
    // ==========================================
    // port bit of a port number
    function [PORTS-1:0] port_bit;
        input [PW-1:0] p;
        begin
            port_bit = {{(PORTS-1){1'b0}}, 1'b1} << p;
        end
    endfunction
    // ==========================================
    // lowest-numbered port offering a frame
    always @*
    begin
        sel = {PW{1'b0}};
        sel_ok = 1'b0;
        for (i = PORTS - 1; i >= 0; i = i - 1)
            if (rx_valid_i[i])
            begin
                sel = i[PW-1:0];
                sel_ok = 1'b1;
            end
    end
    // ==========================================
    // table search for destination and source
    always @*
    begin
        hit = 1'b0;
        hit_port = {PW{1'b0}};
        src_hit = 1'b0;
        src_idx = tbl_next;
        for (j = 0; j < TBL; j = j + 1)
        begin
            if (tbl_valid[j] && tbl_addr[j] == dst)
            begin
                hit = 1'b1; // R01
                hit_port = tbl_port[j];
            end
            if (tbl_valid[j] && tbl_addr[j] == src)
            begin
                src_hit = 1'b1; // R13
                src_idx = j[$clog2(TBL)-1:0];
            end
        end
    end
    // ==========================================
    // link status outputs
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            port_active_o <= {PORTS{1'b0}};
            port_mode_o <= {(PORTS*2){1'b0}};
            an_start_o <= {PORTS{1'b0}};
        end
        else
        begin
            port_active_o <= act;
            port_mode_o <= mode;
            an_start_o <= an_st;
        end
    end
    // ==========================================
    // frame buffer, learning and forwarding
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_IDLE;
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            len <= {AW{1'b0}};
            in_port <= {PW{1'b0}};
            dst <= 48'h0;
            src <= 48'h0;
            egress <= {PORTS{1'b0}};
            tbl_valid <= {TBL{1'b0}};
            tbl_next <= {$clog2(TBL){1'b0}};
            tx_valid_o <= {PORTS{1'b0}};
            tx_data_o <= 8'h0;
            tx_last_o <= 1'b0;
            rx_ready_o <= {PORTS{1'b0}};
        end
        else
            case (state)
                ST_IDLE:
                begin
                    tx_valid_o <= {PORTS{1'b0}};
                    tx_last_o <= 1'b0;
                    wr_ptr <= {AW{1'b0}};
                    if (sel_ok)
                    begin
                        in_port <= sel;
                        rx_ready_o <= port_bit(sel);
                        state <= ST_RECV;
                    end
                end
                ST_RECV:
                    if (rx_valid_i[in_port])
                    begin
                        buffer[wr_ptr] <= rx_data_i[in_port*8 +: 8]; // R06
                        if (wr_ptr <= `LSW_DA_LAST)
                            dst <= {dst[39:0], rx_data_i[in_port*8 +: 8]};
                        else if (wr_ptr <= `LSW_SA_LAST)
                            src <= {src[39:0], rx_data_i[in_port*8 +: 8]};
                        if (wr_ptr != MAXLEN - 1)
                            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
                        if (rx_last_i[in_port])
                        begin
                            rx_ready_o <= {PORTS{1'b0}};
                            len <= wr_ptr;
                            state <= rx_good_i[in_port] ? ST_LOOK : ST_IDLE;
                        end
                    end
                ST_LOOK:
                begin
                    // learn source (also covers a replying station)
                    tbl_valid[src_idx] <= 1'b1; // R03 R05 R13
                    tbl_addr[src_idx] <= src; // R13
                    tbl_port[src_idx] <= in_port; // R05
                    if (!src_hit)
                        tbl_next <= tbl_next + {{($clog2(TBL)-1){1'b0}}, 1'b1};
                    // choose egress set
                    if (dst[40+`LSW_GROUP_BIT])
                        egress <= act & ~port_bit(in_port); // R02 R12
                    else if (hit)
                        egress <= port_bit(hit_port) & act & ~port_bit(in_port); // R01
                    else
                        egress <= act & ~port_bit(in_port); // R04 R12
                    rd_ptr <= {AW{1'b0}};
                    state <= ST_SEND;
                end
                ST_SEND:
                begin
                    // full frame stored before first byte leaves
                    if (egress == {PORTS{1'b0}})
                        state <= ST_IDLE;
                    else if (!tx_valid_o[0] && tx_valid_o == {PORTS{1'b0}})
                    begin
                        tx_valid_o <= egress; // R06
                        tx_data_o <= buffer[rd_ptr];
                        tx_last_o <= (rd_ptr == len);
                    end
                    else if ((tx_ready_i & egress) == egress)
                    begin
                        if (tx_last_o)
                        begin
                            tx_valid_o <= {PORTS{1'b0}};
                            tx_last_o <= 1'b0;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            tx_data_o <= buffer[rd_ptr + {{(AW-1){1'b0}}, 1'b1}];
                            tx_last_o <= (rd_ptr + {{(AW-1){1'b0}}, 1'b1} == len);
                            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
    end
    // full duplex: one shared state machine, so no port receives while the core transmits, no collision logic  R10
endmodule // lsw_switch
